// ==== shared/synth_cfg_pkg.sv ====
package synth_cfg_pkg;

	localparam int unsigned NUM_SETS = 4;
	localparam int unsigned RATIO_W = 32;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned GLOBAL_W = 7;
	localparam int unsigned MODAL_STRIDE = 4;
	localparam int unsigned MODAL_W = NUM_SETS * MODAL_STRIDE;
	localparam int unsigned IRQ_W = 4;

	localparam logic [7:0] OFS_GLOBAL = 8'h00;
	localparam logic [7:0] OFS_MODAL = 8'h04;
	localparam logic [7:0] OFS_RATIO0 = 8'h08;
	localparam logic [7:0] OFS_RATIO_STEP = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_EFF_RATIO = 8'h1c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;

	localparam int unsigned GBL_LOCK_CFG_BIT = 0;
	localparam int unsigned GBL_PREDIV_LSB = 1;
	localparam int unsigned GBL_KEEP_BIT = 3;
	localparam int unsigned GBL_MAP_LSB = 4;
	localparam int unsigned MODAL_RMOD_LSB = 0;
	localparam int unsigned MODAL_AUX_LSB = 2;

	localparam int unsigned STAT_LOCKED_BIT = 0;
	localparam int unsigned STAT_SET_LSB = 1;
	localparam int unsigned STAT_AUX_SRC_LSB = 3;
	localparam int unsigned STAT_CLK_RUN_BIT = 5;
	localparam int unsigned STAT_AUX_RUN_BIT = 6;
	localparam int unsigned STAT_RMOD_BIT = 7;

	localparam int unsigned IRQ_LOCK_LOST = 0;
	localparam int unsigned IRQ_LOCK_GAINED = 1;
	localparam int unsigned IRQ_SET_CHANGE = 2;
	localparam int unsigned IRQ_RESERVED = 3;

	localparam logic [GLOBAL_W-1:0] GLOBAL_RST = 7'h00;
	localparam logic [MODAL_W-1:0] MODAL_RST = 16'h0000;
	localparam logic [RATIO_W-1:0] RATIO_RST = 32'h0010_0000;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

	localparam logic [2:0] RMOD_SHIFT_BASE = 3'h1;
	localparam logic [1:0] PREDIV_LAST_DIV4 = 2'h3;
	localparam logic [1:0] PREDIV_LAST_DIV2 = 2'h1;
	localparam logic [1:0] PREDIV_LAST_DIV1 = 2'h0;

	typedef enum logic [1:0] {
		AUX_REF = 2'b00,
		AUX_RSVD = 2'b01,
		AUX_PLL = 2'b10,
		AUX_LOCK = 2'b11
	} aux_src_e;

	typedef enum logic [1:0] {
		PREDIV_4 = 2'b00,
		PREDIV_2 = 2'b01,
		PREDIV_1 = 2'b10,
		PREDIV_RSVD = 2'b11
	} prediv_e;

	typedef enum logic [2:0] {
		SF_DIS_CLK = 3'b000,
		SF_DIS_AUX = 3'b001,
		SF_DIS_BOTH = 3'b010,
		SF_RMOD_EN = 3'b011,
		SF_RSVD4 = 3'b100,
		SF_RSVD5 = 3'b101,
		SF_RSVD6 = 3'b110,
		SF_AUX_PLL = 3'b111
	} sfmap_e;

endpackage : synth_cfg_pkg

// ==== design/synth_output_config_control.sv ====
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - The auxiliary source select routes the reference clock for 00, the PLL clock for 10 and the lock indicator for 11.
// - Four separate 32-bit user ratio values are held, one per modal set.
// - The lock pin drive config only matters while the auxiliary pin carries the lock indicator.
// - With drive config 0 the auxiliary pin is driven high while unlocked and low while locked.
// - With drive config 1 the auxiliary pin pulls low while unlocked and floats while locked.
// - The reference predivider divides by 4 for 00, by 2 for 01 and by 1 for 10.
// - With keep outputs on unlock at 0, every clock output is held low while the PLL is unlocked.
// - With keep outputs on unlock at 1, clock outputs pass the synthesizer output whatever the lock state.
// - Special map 000 disables the main clock pin, 001 the auxiliary pin and 010 both.
// - Special map 011 makes the special pin the ratio modifier enable, without which no modifier applies.
// - Special map 111 with the special pin high forces the auxiliary source to the PLL clock.
// - In the disable maps a low special pin enables the outputs and a high one disables them.
// - The two set select pins choose which modal set and user ratio are applied.
// - The ratio modifier right-shifts the ratio by 1, 2, 3 or 4 for codes 00, 01, 10 and 11.
// - Enabling, disabling, clock source switching and unlock gating never cut a clock period short, except aux switches to or from the lock indicator.
module synth_output_config_control
	import synth_cfg_pkg::*;
#(
	parameter int unsigned PADDR_W = 8
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [synth_cfg_pkg::DATA_W-1:0] pwdata,
	output logic [synth_cfg_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] set_select,
	input wire logic special_function_pin,
	input wire logic reference_clock_signal,
	input wire logic pll_clock,
	input wire logic pll_locked,
	output logic clk_out,
	output logic clk_out_oe_b,
	output logic aux_out,
	output logic aux_out_oe_b,
	output logic ref_tick,
	output logic [synth_cfg_pkg::RATIO_W-1:0] effective_ratio,
	output logic irq
);
	import synth_cfg_pkg::*;

	if (PADDR_W < 6 || PADDR_W > 32)
	begin : g_bad_addr
		$error("PADDR_W must lie between 6 and 32.");
	end

	function automatic logic hit(input logic [PADDR_W-1:0] a, input logic [7:0] ofs);
		hit = (a == PADDR_W'(ofs));
	endfunction : hit

	function automatic logic src_level(input aux_src_e s, input logic refc, input logic pllc);
		unique case (s)
			AUX_REF: src_level = refc;
			AUX_PLL: src_level = pllc;
			AUX_RSVD, AUX_LOCK: src_level = 1'b0;
		endcase
	endfunction : src_level

	logic [GLOBAL_W-1:0] global_ff, nxt_global;
	logic [MODAL_W-1:0] modal_ff, nxt_modal;
	logic [RATIO_W-1:0] ratio_ff [NUM_SETS];
	logic [RATIO_W-1:0] nxt_ratio [NUM_SETS];
	logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat, irq_en_ff, nxt_irq_en;
	logic [DATA_W-1:0] prdata_ff, nxt_prdata;
	logic locked_prev_ff, nxt_locked_prev;
	logic [1:0] set_prev_ff, nxt_set_prev;
	logic clk_run_ff, nxt_clk_run, clk_oe_ff, nxt_clk_oe, clk_out_ff, nxt_clk_out;
	aux_src_e aux_src_ff, nxt_aux_src;
	logic aux_run_ff, nxt_aux_run, aux_oe_ff, nxt_aux_oe;
	logic aux_out_ff, nxt_aux_out, aux_oe_b_ff, nxt_aux_oe_b;
	logic [1:0] div_cnt_ff, nxt_div_cnt;
	logic ref_tick_ff, nxt_ref_tick;
	logic [RATIO_W-1:0] eff_ratio_ff, nxt_eff_ratio;

	logic setup, wr_en, mapped;
	logic lock_cfg, keep_on_unlock;
	prediv_e prediv;
	sfmap_e sf_map;
	logic [MODAL_STRIDE-1:0] act_modal;
	aux_src_e want_src;
	logic m2_clk_dis, m2_aux_dis, rmod_on, unlock_gate;
	logic [IRQ_W-1:0] events;
	logic [1:0] div_last;

	// Decode of the applied configuration.
	always_comb
	begin
		lock_cfg = global_ff[GBL_LOCK_CFG_BIT];
		keep_on_unlock = global_ff[GBL_KEEP_BIT];
		prediv = prediv_e'(global_ff[GBL_PREDIV_LSB +: 2]);
		sf_map = sfmap_e'(global_ff[GBL_MAP_LSB +: 3]);
		act_modal = modal_ff[set_select * MODAL_STRIDE +: MODAL_STRIDE];
		m2_clk_dis = 1'b0;
		m2_aux_dis = 1'b0;
		rmod_on = 1'b0;
		want_src = aux_src_e'(act_modal[MODAL_AUX_LSB +: 2]);
		unique case (sf_map)
			SF_DIS_CLK: m2_clk_dis = special_function_pin;
			SF_DIS_AUX: m2_aux_dis = special_function_pin;
			SF_DIS_BOTH:
			begin
				m2_clk_dis = special_function_pin;
				m2_aux_dis = special_function_pin;
			end
			SF_RMOD_EN: rmod_on = special_function_pin;
			SF_AUX_PLL: want_src = special_function_pin ? AUX_PLL : want_src;
			SF_RSVD4, SF_RSVD5, SF_RSVD6: rmod_on = 1'b0;
		endcase
		unlock_gate = !pll_locked && !keep_on_unlock;
	end

	// Output gating: changes are taken only while the affected pin sits low, except when the aux pin carries or takes the lock indicator.
	always_comb
	begin
		nxt_clk_run = clk_run_ff;
		nxt_clk_oe = clk_oe_ff;
		if (!pll_clock && !clk_out_ff)
		begin
			nxt_clk_run = !unlock_gate;
			nxt_clk_oe = !m2_clk_dis;
		end
		nxt_clk_out = clk_run_ff && clk_oe_ff && pll_clock;
		nxt_aux_src = aux_src_ff;
		nxt_aux_run = aux_run_ff;
		nxt_aux_oe = aux_oe_ff;
		// The lock indicator is a level, so switching to or from it cannot wait for a low phase.
		if ((aux_src_ff == AUX_LOCK) || (want_src == AUX_LOCK) ||
			(!aux_out_ff && !src_level(aux_src_ff, reference_clock_signal, pll_clock) &&
			!src_level(want_src, reference_clock_signal, pll_clock)))
		begin
			nxt_aux_src = want_src;
			nxt_aux_run = !unlock_gate;
			nxt_aux_oe = !m2_aux_dis;
		end
		unique case (aux_src_ff)
			AUX_REF, AUX_PLL:
			begin
				nxt_aux_out = aux_run_ff && aux_oe_ff &&
					src_level(aux_src_ff, reference_clock_signal, pll_clock);
				nxt_aux_oe_b = !aux_oe_ff;
			end
			AUX_LOCK:
			begin
				if (lock_cfg)
				begin
					nxt_aux_out = 1'b0;
					nxt_aux_oe_b = pll_locked || !aux_oe_ff;
				end
				else
				begin
					nxt_aux_out = !pll_locked;
					nxt_aux_oe_b = !aux_oe_ff;
				end
			end
			AUX_RSVD:
			begin
				nxt_aux_out = 1'b0;
				nxt_aux_oe_b = !aux_oe_ff;
			end
		endcase
	end

	// Reference predivider and effective ratio.
	always_comb
	begin
		unique case (prediv)
			PREDIV_4: div_last = PREDIV_LAST_DIV4;
			PREDIV_2: div_last = PREDIV_LAST_DIV2;
			PREDIV_1: div_last = PREDIV_LAST_DIV1;
			PREDIV_RSVD: div_last = PREDIV_LAST_DIV4;
		endcase
		nxt_div_cnt = (div_cnt_ff >= div_last) ? 2'h0 : div_cnt_ff + 2'h1;
		nxt_ref_tick = (div_cnt_ff >= div_last);
		if (rmod_on)
			nxt_eff_ratio = ratio_ff[set_select] >> (RMOD_SHIFT_BASE + {1'b0, act_modal[MODAL_RMOD_LSB +: 2]});
		else
			nxt_eff_ratio = ratio_ff[set_select];
	end

	// Register bus and interrupt state.
	always_comb
	begin
		setup = psel && !penable;
		wr_en = psel && penable && pwrite;
		mapped = hit(paddr, OFS_GLOBAL) || hit(paddr, OFS_MODAL) || hit(paddr, OFS_STATUS) ||
			hit(paddr, OFS_EFF_RATIO) || hit(paddr, OFS_IRQ_STATUS) || hit(paddr, OFS_IRQ_CLEAR) ||
			hit(paddr, OFS_IRQ_ENABLE);
		nxt_global = global_ff;
		nxt_modal = modal_ff;
		nxt_irq_en = irq_en_ff;
		nxt_prdata = prdata_ff;
		for (int i = 0; i < NUM_SETS; i++)
		begin
			nxt_ratio[i] = ratio_ff[i];
			if (hit(paddr, OFS_RATIO0 + 8'(i) * OFS_RATIO_STEP))
			begin
				mapped = 1'b1;
				if (wr_en)
					nxt_ratio[i] = pwdata;
				if (setup)
					nxt_prdata = ratio_ff[i];
			end
		end
		if (wr_en && hit(paddr, OFS_GLOBAL))
			nxt_global = pwdata[GLOBAL_W-1:0];
		if (wr_en && hit(paddr, OFS_MODAL))
			nxt_modal = pwdata[MODAL_W-1:0];
		if (wr_en && hit(paddr, OFS_IRQ_ENABLE))
			nxt_irq_en = pwdata[IRQ_W-1:0];
		events = '0;
		events[IRQ_LOCK_LOST] = locked_prev_ff && !pll_locked;
		events[IRQ_LOCK_GAINED] = !locked_prev_ff && pll_locked;
		events[IRQ_SET_CHANGE] = (set_prev_ff != set_select);
		events[IRQ_RESERVED] = (want_src == AUX_RSVD) || (prediv == PREDIV_RSVD);
		// An event in the clearing cycle survives the clear.
		nxt_irq_stat = irq_stat_ff | events;
		if (wr_en && hit(paddr, OFS_IRQ_CLEAR))
			nxt_irq_stat = (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | events;
		nxt_locked_prev = pll_locked;
		nxt_set_prev = set_select;
		if (setup)
		begin
			if (hit(paddr, OFS_GLOBAL))
				nxt_prdata = DATA_W'(global_ff);
			else if (hit(paddr, OFS_MODAL))
				nxt_prdata = DATA_W'(modal_ff);
			else if (hit(paddr, OFS_STATUS))
			begin
				nxt_prdata = '0;
				nxt_prdata[STAT_LOCKED_BIT] = pll_locked;
				nxt_prdata[STAT_SET_LSB +: 2] = set_select;
				nxt_prdata[STAT_AUX_SRC_LSB +: 2] = aux_src_ff;
				nxt_prdata[STAT_CLK_RUN_BIT] = clk_run_ff && clk_oe_ff;
				nxt_prdata[STAT_AUX_RUN_BIT] = aux_run_ff && aux_oe_ff;
				nxt_prdata[STAT_RMOD_BIT] = rmod_on;
			end
			else if (hit(paddr, OFS_EFF_RATIO))
				nxt_prdata = eff_ratio_ff;
			else if (hit(paddr, OFS_IRQ_STATUS))
				nxt_prdata = DATA_W'(irq_stat_ff);
			else if (hit(paddr, OFS_IRQ_ENABLE))
				nxt_prdata = DATA_W'(irq_en_ff);
			else if (!mapped || hit(paddr, OFS_IRQ_CLEAR))
				nxt_prdata = '0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			global_ff <= GLOBAL_RST;
			modal_ff <= MODAL_RST;
			for (int i = 0; i < NUM_SETS; i++)
				ratio_ff[i] <= RATIO_RST;
			irq_stat_ff <= IRQ_RST;
			irq_en_ff <= IRQ_RST;
			prdata_ff <= '0;
			locked_prev_ff <= 1'b0;
			set_prev_ff <= 2'h0;
		end
		else
		begin
			global_ff <= nxt_global;
			modal_ff <= nxt_modal;
			ratio_ff <= nxt_ratio;
			irq_stat_ff <= nxt_irq_stat;
			irq_en_ff <= nxt_irq_en;
			prdata_ff <= nxt_prdata;
			locked_prev_ff <= nxt_locked_prev;
			set_prev_ff <= nxt_set_prev;
		end
	end

	// Output gate and pin registers.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			clk_run_ff <= 1'b0;
			clk_oe_ff <= 1'b0;
			clk_out_ff <= 1'b0;
			aux_src_ff <= AUX_REF;
			aux_run_ff <= 1'b0;
			aux_oe_ff <= 1'b0;
			aux_out_ff <= 1'b0;
			aux_oe_b_ff <= 1'b1;
		end
		else
		begin
			clk_run_ff <= nxt_clk_run;
			clk_oe_ff <= nxt_clk_oe;
			clk_out_ff <= nxt_clk_out;
			aux_src_ff <= nxt_aux_src;
			aux_run_ff <= nxt_aux_run;
			aux_oe_ff <= nxt_aux_oe;
			aux_out_ff <= nxt_aux_out;
			aux_oe_b_ff <= nxt_aux_oe_b;
		end
	end

	// Predivider and effective ratio registers.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			div_cnt_ff <= 2'h0;
			ref_tick_ff <= 1'b0;
			eff_ratio_ff <= '0;
		end
		else
		begin
			div_cnt_ff <= nxt_div_cnt;
			ref_tick_ff <= nxt_ref_tick;
			eff_ratio_ff <= nxt_eff_ratio;
		end
	end

	// Zero wait states keep the slave simple; read data is captured in the setup cycle.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_ff;
	assign clk_out = clk_out_ff;
	assign clk_out_oe_b = !clk_oe_ff;
	assign aux_out = aux_out_ff;
	assign aux_out_oe_b = aux_oe_b_ff;
	assign ref_tick = ref_tick_ff;
	assign effective_ratio = eff_ratio_ff;
	assign irq = |(irq_stat_ff & irq_en_ff);

endmodule : synth_output_config_control

`default_nettype wire

// ==== verification/synth_board_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module synth_board_model
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [1:0] want_set,
	input wire logic want_pin,
	input wire logic want_lock,
	output logic [1:0] set_select,
	output logic special_function_pin,
	output logic reference_clock_signal,
	output logic pll_clock,
	output logic pll_locked
);
	logic [1:0] pll_ff, nxt_pll, set_ff, nxt_set;
	logic [2:0] ref_ff, nxt_ref;
	logic pin_ff, nxt_pin, lock_ff, nxt_lock;
	// Clock periods of 4 and 6 mclk cycles, so a source switch meets 12 of the 24 phase pairings.
	always_comb
	begin
		nxt_pll = pll_ff + 2'd1;
		nxt_ref = (ref_ff == 3'd5) ? 3'd0 : ref_ff + 3'd1;
		nxt_set = want_set;
		nxt_pin = want_pin;
		nxt_lock = want_lock;
	end
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pll_ff <= 2'h0;
			ref_ff <= 3'h0;
			set_ff <= 2'h0;
			pin_ff <= 1'b0;
			lock_ff <= 1'b0;
		end
		else
		begin
			pll_ff <= nxt_pll;
			ref_ff <= nxt_ref;
			set_ff <= nxt_set;
			pin_ff <= nxt_pin;
			lock_ff <= nxt_lock;
		end
	end
	assign pll_clock = pll_ff[1];
	assign reference_clock_signal = ref_ff > 3'd2;
	assign set_select = set_ff;
	assign special_function_pin = pin_ff;
	assign pll_locked = lock_ff;
endmodule : synth_board_model
`default_nettype wire

// ==== verification/synth_output_config_control_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module synth_output_config_control_checker
#(
	parameter int unsigned PADDR_W = 8
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [synth_cfg_pkg::DATA_W-1:0] pwdata,
	input wire logic [1:0] set_select,
	input wire logic special_function_pin,
	input wire logic pll_clock,
	input wire logic pll_locked,
	input wire logic clk_out,
	input wire logic clk_out_oe_b,
	input wire logic aux_out,
	input wire logic aux_out_oe_b
);
	import synth_cfg_pkg::*;
	logic [6:0] gbl_ff, nxt_gbl;
	logic [15:0] mod_ff, nxt_mod;
	logic [2:0] map;
	logic [1:0] src;
	logic wr, sfp, cd, ad, lk;
	always_comb
	begin
		wr = psel && penable && pwrite;
		nxt_gbl = (wr && paddr == PADDR_W'(0)) ? pwdata[6:0] : gbl_ff;
		nxt_mod = (wr && paddr == PADDR_W'(4)) ? pwdata[15:0] : mod_ff;
	end
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			gbl_ff <= 7'h00;
			mod_ff <= 16'h0000;
		end
		else
		begin
			gbl_ff <= nxt_gbl;
			mod_ff <= nxt_mod;
		end
	end
	assign map = gbl_ff[6:4];
	assign src = mod_ff[{set_select, 2'b10} +: 2];
	assign sfp = special_function_pin;
	assign cd = sfp && map inside {3'd0, 3'd2};
	assign ad = sfp && map inside {3'd1, 3'd2};
	assign lk = !(sfp && map inside {3'd1, 3'd2, 3'd7}) && src == 2'b11;
	// Windows leave room for gate changes, which wait until both clocks are low.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	a_unlock_low: assert property ((!gbl_ff[3] && !pll_locked)[*6] |-> !clk_out)
		else $error("clock output runs while unlocked");
	a_keep_pass: assert property ((gbl_ff[3] && !cd)[*6] |-> clk_out == $past(pll_clock))
		else $error("clock output not passed through");
	a_clk_off: assert property (cd[*6] |-> clk_out_oe_b)
		else $error("clock pin not released");
	a_clk_on: assert property ((!cd)[*6] |-> !clk_out_oe_b)
		else $error("clock pin not driven");
	a_aux_off: assert property (ad[*8] |-> aux_out_oe_b)
		else $error("aux pin not released");
	a_lock_push: assert property ((lk && !gbl_ff[0] && $stable(pll_locked))[*3]
		|-> aux_out == !pll_locked && !aux_out_oe_b) else $error("push-pull lock pin wrong");
	a_lock_drain: assert property ((lk && gbl_ff[0] && $stable(pll_locked))[*3]
		|-> !aux_out && aux_out_oe_b == pll_locked) else $error("open-drain lock pin wrong");
	a_aux_route: assert property (((src == 2'b10 || (map == 3'd7 && sfp)) && !ad && pll_locked)[*8]
		|-> aux_out == $past(pll_clock)) else $error("aux pin not carrying the pll clock");
	a_clk_high_whole: assert property ($rose(clk_out) |=> clk_out)
		else $error("clock output high phase cut short");
	a_clk_low_whole: assert property ($fell(clk_out) |=> !clk_out)
		else $error("clock output low phase cut short");
endmodule : synth_output_config_control_checker
`default_nettype wire

// ==== verification/synth_output_config_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module synth_output_config_control_test;
	import synth_cfg_pkg::*;
	logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, ref_tick, irq, want_pin, want_lock;
	logic special_function_pin, reference_clock_signal, pll_clock, pll_locked;
	logic clk_out, clk_out_oe_b, aux_out, aux_out_oe_b;
	logic [1:0] set_select, want_set;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, effective_ratio;
	logic [31:0] ratio [4] = '{32'h0013_a92a, 32'h1000_0000, 32'h0030_0000, 32'h00ff_fff0};
	int n_fail = 0;
	int n_compared = 0;
	synth_output_config_control uut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .set_select(set_select), .special_function_pin(special_function_pin),
		.reference_clock_signal(reference_clock_signal), .pll_clock(pll_clock), .pll_locked(pll_locked),
		.clk_out(clk_out), .clk_out_oe_b(clk_out_oe_b), .aux_out(aux_out), .aux_out_oe_b(aux_out_oe_b),
		.ref_tick(ref_tick), .effective_ratio(effective_ratio), .irq(irq));
	synth_board_model partner (.mclk(mclk), .rst_b(rst_b), .want_set(want_set), .want_pin(want_pin),
		.want_lock(want_lock), .set_select(set_select), .special_function_pin(special_function_pin),
		.reference_clock_signal(reference_clock_signal), .pll_clock(pll_clock), .pll_locked(pll_locked));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("Error %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] q);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		q = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [32:0] q;
		apb(1'b1, a, d, q);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [32:0] exp);
		logic [32:0] q;
		apb(1'b0, a, 32'h0, q);
		chk(q[31:0], exp[31:0]);
		chk({31'h0, q[32]}, {31'h0, exp[32]});
	endtask : rdc
	task automatic pins(input logic [1:0] s, input logic p, input logic l, input int n);
		want_set <= s;
		want_pin <= p;
		want_lock <= l;
		repeat (n) @(posedge mclk);
	endtask : pins
	task automatic t_regs;
		rdc(8'h00, 33'h0);
		rdc(8'h04, 33'h0);
		rdc(8'h30, 33'h1_0000_0000);
		for (int i = 0; i < 4; i++)
		begin
			rdc(8'(8 + 4 * i), {1'b0, 32'h0010_0000});
			wr(8'(8 + 4 * i), ratio[i]);
		end
		for (int i = 0; i < 4; i++)
			rdc(8'(8 + 4 * i), {1'b0, ratio[i]});
		$display("t_regs finished");
	endtask : t_regs
	task automatic t_sets;
		for (int s = 0; s < 4; s++)
		begin
			pins(2'(s), 1'b0, 1'b1, 4);
			chk(effective_ratio, ratio[s]);
			rdc(8'h1c, {1'b0, ratio[s]});
			rdc(8'h18, {1'b0, 32'h0000_0061 | 32'(2 * s)});
		end
		$display("t_sets finished");
	endtask : t_sets
	task automatic t_rmod;
		wr(8'h04, 32'h0000_3210);
		for (int s = 0; s < 4; s++)
		begin
			wr(8'h00, 32'h0000_0030);
			pins(2'(s), 1'b0, 1'b1, 4);
			chk(effective_ratio, ratio[s]);
			pins(2'(s), 1'b1, 1'b1, 4);
			chk(effective_ratio, ratio[s] >> (s + 1));
			wr(8'h00, 32'h0000_0040);
			pins(2'(s), 1'b1, 1'b1, 4);
			chk(effective_ratio, ratio[s]);
		end
		$display("t_rmod finished");
	endtask : t_rmod
	task automatic t_irq;
		wr(8'h00, 32'h0);
		wr(8'h28, 32'h1);
		wr(8'h24, 32'hf);
		chk({31'h0, irq}, 32'h0);
		pins(2'b11, 1'b0, 1'b0, 4);
		chk({31'h0, irq}, 32'h1);
		rdc(8'h20, {1'b0, 32'h0000_0001});
		rdc(8'h28, {1'b0, 32'h0000_0001});
		rdc(8'h24, 33'h0);
		wr(8'h28, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(8'h28, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(8'h24, 32'h1);
		chk({31'h0, irq}, 32'h0);
		pins(2'b11, 1'b0, 1'b1, 4);
		$display("t_irq finished");
	endtask : t_irq
	task automatic t_prediv;
		int cnt;
		for (int c = 0; c < 3; c++)
		begin
			wr(8'h00, 32'(c * 2));
			repeat (8) @(posedge mclk);
			cnt = 0;
			repeat (12)
			begin
				@(negedge mclk);
				if (ref_tick === 1'b1)
					cnt++;
			end
			@(posedge mclk);
			chk(32'(cnt), 32'(12 / (4 >> c)));
		end
		$display("t_prediv finished");
	endtask : t_prediv
	task automatic t_pins;
		logic [2:0] m;
		for (int j = 0; j < 2; j++)
		begin
			wr(8'h04, j ? 32'h8888 : 32'hcccc);
			for (int g = 0; g < 8; g++)
			begin
				m = 3'(g);
				wr(8'h00, {25'h0, m, m[1], 2'b10, m[0]});
				for (int p = 0; p < 4; p++)
				begin
					pins(2'(g), p[1], p[0], 10);
					chk({31'h0, clk_out_oe_b}, {31'h0, p[1] && (m == 3'd0 || m == 3'd2)});
				end
			end
		end
		$display("t_pins finished");
	endtask : t_pins
	task automatic wrap_up;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial
	begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		want_set = 2'b00;
		want_pin = 1'b0;
		want_lock = 1'b1;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		t_regs;
		t_sets;
		t_rmod;
		t_irq;
		t_prediv;
		t_pins;
		wrap_up;
	end
	initial
	begin
		#400000;
		$display("Error %0t: watchdog expired", $time);
		n_fail++;
		wrap_up;
	end
endmodule : synth_output_config_control_test
bind synth_output_config_control synth_output_config_control_checker #(.PADDR_W(PADDR_W)) checker_i (
	.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .set_select(set_select), .special_function_pin(special_function_pin),
	.pll_clock(pll_clock), .pll_locked(pll_locked), .clk_out(clk_out), .clk_out_oe_b(clk_out_oe_b),
	.aux_out(aux_out), .aux_out_oe_b(aux_out_oe_b));
`default_nettype wire
